// ===== core/uart_dp_regs.vh
// Constants for the serial transmit and receive datapath.
// Included by the datapath design file; holds definitions only.
`ifndef UART_DP_REGS_VH
`define UART_DP_REGS_VH

// Character size codes
`define CHAR_SIZE_5 3'h0
`define CHAR_SIZE_6 3'h1
`define CHAR_SIZE_7 3'h2
`define CHAR_SIZE_8 3'h3
`define CHAR_SIZE_9 3'h7

// Data bits per character code
`define DATA_BITS_5 4'h5
`define DATA_BITS_8 4'h8
`define DATA_BITS_9 4'h9

// Oversampling lengths of the asynchronous baud divider
`define OS_NORMAL 5'h10
`define OS_DOUBLE 5'h08

// Frame and buffer geometry
`define FRAME_MAX 13
`define CHAR_WIDTH 9
`define RX_FIFO_DEPTH 8
`define RX_FIFO_ADDR 3

// Width of the baud divider setting
`define BAUD_WIDTH 12

`endif

// ===== core/uart_tx_rx_datapath.v
// Serial transmitter and receiver datapath with a receive FIFO.
// Assumes one 100 MHz clock, configuration held steady by the core
// while frames run, and pins that cross in from outside the clock domain.
// Operation
// - Transmit enable takes over the output pin
// - Synchronous mode shifts on external serial clock
// - Data write loads buffer; moves when shifter idle
// - Shifter sends frame at selected bit rate
// - Unused upper transmit bits are ignored
// - Size code 7 sends ninth bit on top
// - Buffer empty flag tracks transmit buffer
// - Writing data clears buffer empty flag
// - Buffer empty interrupt requested while flag set
// - Transmit complete sets after frame, nothing waiting
// - Transmit complete clears on service or write-one
// - Transmit complete interrupt requested while flag set
// - Parity bit between last data and stop
// - Transmit disable waits until shifter and buffer empty
// - Receive enable takes over the input pin
// - Receive begins on valid start, samples bits
// - First stop bit ends frame, second ignored
// - Completed frame moves into receive buffer
// - Unused upper received bits read zero
// - Async divider is 16 or 8 times setting+1
// - Start, data LSB first, parity, stops; idle high
// - Parity is XOR of data, inverted for odd
// - Polarity picks change and sample clock edges
`include "uart_dp_regs.vh"
`timescale 1ns/1ns

// Small synchronous FIFO with valid and ready on both sides
module uart_rx_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst_n,
   input wire i_flush,
   // Filling side
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [WIDTH-1:0] i_in_data,
   // Draining side
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [WIDTH-1:0] o_out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
   reg [AW-1:0] wr_ptr; // Next slot to fill
   reg [AW-1:0] rd_ptr; // Oldest word
   reg [AW:0] count; // Words held
   wire push; // Word accepted this cycle
   wire pop; // Word drained this cycle

   assign o_in_ready = (count != DEPTH[AW:0]);
   assign o_out_valid = (count != {(AW+1){1'b0}});
   assign o_out_data = mem[rd_ptr];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // Pointers and occupancy; flush empties the buffer at once
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else if (i_flush) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end

   // Storage has no reset; only slots behind the count are ever read
   always @(posedge i_clk) begin
      if (push & ~i_flush) begin
         mem[wr_ptr] <= i_in_data;
      end
   end
endmodule // uart_rx_fifo

module uart_tx_rx_datapath (
   // Clock and reset
   input wire I_CLK,
   input wire I_RSTN,
   // Frame and rate configuration
   input wire I_TX_ENABLE_BIT,
   input wire I_RX_ENABLE_BIT,
   input wire I_SYNC_MODE,
   input wire I_DOUBLE_SPEED_BIT,
   input wire [2:0] I_CHAR_SIZE_FIELD,
   input wire I_PARITY_ENABLE_BIT,
   input wire I_PARITY_ODD_SELECT,
   input wire I_STOP_BITS_SELECT,
   input wire I_CLOCK_POLARITY_BIT,
   input wire [11:0] I_BAUD_DIVIDER,
   input wire I_TX_NINTH_BIT,
   // Data location: write and read strobes
   input wire I_DATA_WR,
   input wire [7:0] I_DATA_WDATA,
   input wire I_DATA_RD,
   output wire [8:0] O_DATA_RDATA,
   // Status and interrupt control
   input wire I_BUFFER_EMPTY_IRQ_ENABLE,
   input wire I_TX_COMPLETE_IRQ_ENABLE,
   input wire I_TX_COMPLETE_IRQ_ACK,
   input wire I_TX_COMPLETE_CLEAR,
   output wire O_BUFFER_EMPTY_FLAG,
   output wire O_TX_COMPLETE_FLAG,
   output wire O_RX_COMPLETE_FLAG,
   output wire O_BUFFER_EMPTY_IRQ,
   output wire O_TX_COMPLETE_IRQ,
   // Serial pins
   input wire I_SERIAL_IN_PIN,
   input wire I_SERIAL_CLOCK_PIN,
   output wire O_SERIAL_OUT_PIN,
   output wire O_SERIAL_OUT_OE,
   output wire O_SERIAL_IN_OWNED
);
   localparam RX_IDLE = 2'h0; // Waiting for a start edge
   localparam RX_START = 2'h1; // Checking start bit at mid-bit
   localparam RX_BITS = 2'h2; // Collecting data, parity, stop

   reg rst_meta; // Reset release, first stage
   reg rst_n; // Reset release used by the design
   reg [1:0] xck_sync; // Serial clock synchroniser
   reg xck_prev; // Last synchronised serial clock level
   reg [1:0] rxd_sync; // Input pin synchroniser
   reg [11:0] baud_cnt; // Divider toward one sample tick
   reg sample_tick; // One pulse per (setting+1) cycles
   reg [3:0] tx_os; // Sample ticks into the current bit
   reg [8:0] tx_buf; // Transmit buffer
   reg tx_buf_full; // Buffer holds data not yet shifted
   reg [`FRAME_MAX-1:0] tx_shift; // Frame being sent, bit 0 on the pin
   reg [3:0] tx_left; // Bits of the frame still to finish
   reg tx_busy; // Frame in progress
   reg tx_line; // Registered output pin level
   reg tx_owned; // Transmitter holds the output pin
   reg tx_done; // Transmit complete flag
   reg rx_on; // Receiver holds the input pin
   reg [1:0] rx_state; // Receiver sequence
   reg [3:0] rx_os; // Sample ticks into the current bit
   reg [3:0] rx_idx; // Bits taken after the start bit
   reg [8:0] rx_shift; // Receive shift register
   reg rx_push; // Completed frame offered to the FIFO
   reg [8:0] rx_word; // Frame data offered to the FIFO
   reg [3:0] n_bits; // Data bits per character
   reg [`FRAME_MAX-1:0] next_frame; // Frame built from the buffer
   reg [3:0] next_len; // Bit count of that frame
   reg [8:0] masked; // Buffer with unused bits cleared
   integer i;
   wire [4:0] os_len; // Sample ticks per bit, async
   wire xck_rise; // Serial clock rising edge
   wire xck_fall; // Serial clock falling edge
   wire change_edge; // Edge on which output data changes
   wire sample_edge; // Edge on which input data is taken
   wire tx_bit_end; // Current transmit bit ends now
   wire tx_load; // Buffer moves into the shifter now
   wire rx_event; // Receiver takes a bit now
   wire [3:0] rx_target; // Tick count for the next rx event
   wire [3:0] rx_stop_idx; // Index of the first stop bit
   wire fifo_ready; // FIFO can take a frame
   wire fifo_valid; // FIFO holds unread data

   // Reset is released through two flip-flops
   always @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Pin synchronisers; the first stage feeds only the second
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         xck_sync <= 2'h0;
         xck_prev <= 1'b0;
         rxd_sync <= 2'h3;
      end else begin
         xck_sync <= {xck_sync[0], I_SERIAL_CLOCK_PIN};
         xck_prev <= xck_sync[1];
         rxd_sync <= {rxd_sync[0], I_SERIAL_IN_PIN};
      end
   end

   assign xck_rise = xck_sync[1] & ~xck_prev;
   assign xck_fall = ~xck_sync[1] & xck_prev;
   assign change_edge = I_CLOCK_POLARITY_BIT ? xck_fall : xck_rise;
   assign sample_edge = I_CLOCK_POLARITY_BIT ? xck_rise : xck_fall;

   // Baud divider: one sample tick each (setting+1) clocks
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         baud_cnt <= 12'h000;
         sample_tick <= 1'b0;
      end else if (baud_cnt >= I_BAUD_DIVIDER) begin
         baud_cnt <= 12'h000;
         sample_tick <= 1'b1;
      end else begin
         baud_cnt <= baud_cnt + 12'h001;
         sample_tick <= 1'b0;
      end
   end

   // Bit is 16 ticks, or 8 at double speed
   assign os_len = I_DOUBLE_SPEED_BIT ? `OS_DOUBLE : `OS_NORMAL;

   // Data bits per character; reserved codes behave as eight
   always @* begin
      case (I_CHAR_SIZE_FIELD)
         `CHAR_SIZE_5, `CHAR_SIZE_6, `CHAR_SIZE_7, `CHAR_SIZE_8: begin
            n_bits = `DATA_BITS_5 + {2'h0, I_CHAR_SIZE_FIELD[1:0]};
         end
         `CHAR_SIZE_9: begin
            n_bits = `DATA_BITS_9;
         end
         default: begin
            n_bits = `DATA_BITS_8;
         end
      endcase
   end

   // Frame builder: start low, data LSB first, parity, stops high
   always @* begin
      masked = 9'h000;
      next_frame = {`FRAME_MAX{1'b1}};
      next_frame[0] = 1'b0;
      for (i = 0; i < 9; i = i + 1) begin
         if (i < n_bits) begin
            masked[i] = tx_buf[i];
            next_frame[i+1] = tx_buf[i];
         end
      end
      if (I_PARITY_ENABLE_BIT) begin
         next_frame[n_bits+1] = (^masked) ^ I_PARITY_ODD_SELECT;
      end
      next_len = 4'h2 + n_bits + {3'h0, I_PARITY_ENABLE_BIT} + {3'h0, I_STOP_BITS_SELECT};
   end

   // Bit boundaries: ticks count out a bit, or the change edge in sync
   assign tx_bit_end = I_SYNC_MODE ? change_edge :
                       (sample_tick & (tx_os == os_len[3:0] - 4'h1)) |
                       (sample_tick & (os_len == `OS_NORMAL) & (tx_os == 4'hf));
   // Load when idle, or right as the last stop bit ends; sync waits an edge
   assign tx_load = tx_buf_full & tx_owned &
                    ((~tx_busy & (~I_SYNC_MODE | change_edge)) |
                     (tx_busy & tx_bit_end & (tx_left == 4'h1)));

   // Transmit buffer and its empty flag
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tx_buf <= 9'h000;
         tx_buf_full <= 1'b0;
      end else begin
         if (tx_load) begin
            tx_buf_full <= 1'b0;
         end
         // A write in the load cycle still leaves the buffer full
         if (I_DATA_WR & I_TX_ENABLE_BIT) begin
            tx_buf <= {I_TX_NINTH_BIT & (I_CHAR_SIZE_FIELD == `CHAR_SIZE_9),
                       I_DATA_WDATA};
            tx_buf_full <= 1'b1;
         end
      end
   end

   // Shifter, line level, pin ownership and completion flag
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         tx_shift <= {`FRAME_MAX{1'b1}};
         tx_left <= 4'h0;
         tx_busy <= 1'b0;
         tx_os <= 4'h0;
         tx_line <= 1'b1;
         tx_owned <= 1'b0;
         tx_done <= 1'b0;
      end else begin
         // Pin stays taken until nothing is pending
         tx_owned <= I_TX_ENABLE_BIT | tx_busy | tx_buf_full;
         if (tx_load) begin
            tx_shift <= next_frame;
            tx_left <= next_len;
            tx_busy <= 1'b1;
            tx_os <= 4'h0;
            tx_line <= next_frame[0];
         end else if (tx_busy & tx_bit_end) begin
            tx_os <= 4'h0;
            if (tx_left == 4'h1) begin
               tx_busy <= 1'b0;
               tx_line <= 1'b1;
            end else begin
               tx_shift <= {1'b1, tx_shift[`FRAME_MAX-1:1]};
               tx_line <= tx_shift[1];
            end
            tx_left <= tx_left - 4'h1;
         end else if (tx_busy & sample_tick) begin
            tx_os <= tx_os + 4'h1;
         end
         // Clear first so that a completion in the same cycle wins
         if (I_TX_COMPLETE_CLEAR | (I_TX_COMPLETE_IRQ_ACK & tx_done)) begin
            tx_done <= 1'b0;
         end
         if (tx_busy & tx_bit_end & (tx_left == 4'h1) & ~tx_buf_full) begin
            tx_done <= 1'b1;
         end
      end
   end

   // Receiver timing: half a bit to mid-start, whole bits after
   assign rx_target = (rx_state == RX_START) ? (os_len[4:1] - 4'h1) : (os_len[3:0] - 4'h1);
   assign rx_event = I_SYNC_MODE ? sample_edge :
                     (sample_tick & ((rx_os == rx_target) |
                      ((rx_state != RX_START) & (os_len == `OS_NORMAL) & (rx_os == 4'hf))));
   assign rx_stop_idx = n_bits + {3'h0, I_PARITY_ENABLE_BIT};

   // Receiver sequence; disabling aborts at once
   always @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rx_on <= 1'b0;
         rx_state <= RX_IDLE;
         rx_os <= 4'h0;
         rx_idx <= 4'h0;
         rx_shift <= 9'h000;
         rx_push <= 1'b0;
         rx_word <= 9'h000;
      end else begin
         rx_on <= I_RX_ENABLE_BIT;
         // Offer holds until the FIFO takes it; a full FIFO delays it until a read
         if (rx_push & fifo_ready) begin
            rx_push <= 1'b0;
         end
         if (~I_RX_ENABLE_BIT) begin
            rx_state <= RX_IDLE;
            rx_push <= 1'b0;
         end else begin
            if (sample_tick) begin
               rx_os <= rx_event ? 4'h0 : rx_os + 4'h1;
            end
            case (rx_state)
               RX_IDLE: begin
                  rx_os <= 4'h0;
                  rx_idx <= 4'h0;
                  rx_shift <= 9'h000;
                  if (~rxd_sync[1] & (~I_SYNC_MODE | sample_edge)) begin
                     // Sync takes the start bit on the sampling edge
                     rx_state <= I_SYNC_MODE ? RX_BITS : RX_START;
                  end
               end
               RX_START: begin
                  if (rx_event) begin
                     // A high line at mid-start is a glitch, not a frame
                     rx_state <= rxd_sync[1] ? RX_IDLE : RX_BITS;
                  end
               end
               RX_BITS: begin
                  if (rx_event) begin
                     if (rx_idx < n_bits) begin
                        rx_shift <= {rxd_sync[1], rx_shift[8:1]};
                     end
                     if (rx_idx == rx_stop_idx) begin
                        // Zero fill leaves unused top bits clear
                        rx_word <= rx_shift >> (4'h9 - n_bits);
                        rx_push <= 1'b1;
                        rx_state <= RX_IDLE;
                     end else begin
                        rx_idx <= rx_idx + 4'h1;
                     end
                  end
               end
               default: begin
                  rx_state <= RX_IDLE;
               end
            endcase
         end
      end
   end

   // Receive buffer; disabling the receiver flushes it
   uart_rx_fifo #(
      .WIDTH(`CHAR_WIDTH),
      .DEPTH(`RX_FIFO_DEPTH),
      .AW(`RX_FIFO_ADDR)
   ) u_rx_fifo (
      .i_clk(I_CLK),
      .i_rst_n(rst_n),
      .i_flush(~rx_on),
      .i_in_valid(rx_push),
      .o_in_ready(fifo_ready),
      .i_in_data(rx_word),
      .o_out_valid(fifo_valid),
      .i_out_ready(I_DATA_RD),
      .o_out_data(O_DATA_RDATA)
   );

   assign O_BUFFER_EMPTY_FLAG = ~tx_buf_full;
   assign O_TX_COMPLETE_FLAG = tx_done;
   assign O_RX_COMPLETE_FLAG = fifo_valid;
   assign O_BUFFER_EMPTY_IRQ = I_BUFFER_EMPTY_IRQ_ENABLE & ~tx_buf_full;
   assign O_TX_COMPLETE_IRQ = I_TX_COMPLETE_IRQ_ENABLE & tx_done;
   assign O_SERIAL_OUT_PIN = tx_line;
   assign O_SERIAL_OUT_OE = tx_owned;
   assign O_SERIAL_IN_OWNED = rx_on;
endmodule // uart_tx_rx_datapath

// ===== bench/uart_dp_asserts.sv
// Port checker for the serial transmit and receive datapath.
// Assumes binding onto the datapath top, one clock, async low reset.
`timescale 1ns/1ns
module uart_dp_asserts (
   // Clock and reset
   input wire I_CLK,
   input wire I_RSTN,
   // Controls
   input wire I_TX_ENABLE_BIT,
   input wire I_RX_ENABLE_BIT,
   input wire I_SYNC_MODE,
   input wire [2:0] I_CHAR_SIZE_FIELD,
   input wire [11:0] I_BAUD_DIVIDER,
   input wire I_DATA_WR,
   input wire I_BUFFER_EMPTY_IRQ_ENABLE,
   input wire I_TX_COMPLETE_IRQ_ENABLE,
   input wire I_TX_COMPLETE_IRQ_ACK,
   input wire I_TX_COMPLETE_CLEAR,
   // Status and pins
   input wire [8:0] O_DATA_RDATA,
   input wire O_BUFFER_EMPTY_FLAG,
   input wire O_TX_COMPLETE_FLAG,
   input wire O_RX_COMPLETE_FLAG,
   input wire O_BUFFER_EMPTY_IRQ,
   input wire O_TX_COMPLETE_IRQ,
   input wire O_SERIAL_OUT_PIN,
   input wire O_SERIAL_OUT_OE,
   input wire O_SERIAL_IN_OWNED
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RSTN);
   // Interrupt levels are tied to enable and flag every cycle
   a_empty_irq_level: assert property (
      O_BUFFER_EMPTY_IRQ == (I_BUFFER_EMPTY_IRQ_ENABLE && O_BUFFER_EMPTY_FLAG))
      else $error("buffer empty request wrong");
   a_done_irq_level: assert property (
      O_TX_COMPLETE_IRQ == (I_TX_COMPLETE_IRQ_ENABLE && O_TX_COMPLETE_FLAG))
      else $error("transmit complete request wrong");
   // An accepted write fills the buffer and claims the pin
   a_write_clears_empty: assert property (
      I_DATA_WR && I_TX_ENABLE_BIT |=> !O_BUFFER_EMPTY_FLAG && O_SERIAL_OUT_OE)
      else $error("write did not fill buffer");
   // Completion only with nothing waiting and the line idle high
   a_done_when_idle: assert property (
      $rose(O_TX_COMPLETE_FLAG) |-> O_BUFFER_EMPTY_FLAG && O_SERIAL_OUT_PIN)
      else $error("complete set with data pending");
   // Clearing only safe to judge once the transmitter let go
   a_done_cleared: assert property (
      (I_TX_COMPLETE_IRQ_ACK || I_TX_COMPLETE_CLEAR) && !O_SERIAL_OUT_OE
      |=> !O_TX_COMPLETE_FLAG)
      else $error("complete flag not cleared");
   a_pin_release: assert property (
      $fell(O_SERIAL_OUT_OE) |-> !$past(I_TX_ENABLE_BIT) && O_BUFFER_EMPTY_FLAG)
      else $error("pin released with data pending");
   // With divider zero a start bit lasts many clocks
   a_start_length: assert property (
      $fell(O_SERIAL_OUT_PIN) && O_SERIAL_OUT_OE && !I_SYNC_MODE
      && I_BAUD_DIVIDER == 12'h000 |-> !O_SERIAL_OUT_PIN [*7])
      else $error("start bit too short");
   a_rx_takes_pin: assert property (
      $rose(I_RX_ENABLE_BIT) |-> ##2 O_SERIAL_IN_OWNED)
      else $error("receiver did not take pin");
   a_rx_flush: assert property (
      !I_RX_ENABLE_BIT |-> ##2 !O_RX_COMPLETE_FLAG)
      else $error("receive buffer not flushed");
   a_rx_upper_zero: assert property (
      O_RX_COMPLETE_FLAG && I_CHAR_SIZE_FIELD == 3'h0 |-> O_DATA_RDATA[8:5] == 4'h0)
      else $error("unused received bits not zero");
   // Main scenarios reached
   c_write: cover property (I_DATA_WR && I_TX_ENABLE_BIT);
   c_rx_done: cover property ($rose(O_RX_COMPLETE_FLAG));
   c_release: cover property ($fell(O_SERIAL_OUT_OE));
endmodule // uart_dp_asserts

// ===== bench/uart_peer.sv
// Remote serial transceiver model facing the datapath pins.
// Assumes bit time in system clocks is set by the bench.
`timescale 1ns/1ns
module uart_peer (
   // Clock and bit time
   input wire i_clk,
   input wire [4:0] i_bit_clks,
   // Serial lines
   input wire i_line,
   output reg o_line
);
   integer nb; // Bits captured after start
   integer cnt; // Frames captured
   integer i;
   reg [12:0] got; // Last captured bits, first bit in bit 0
   initial begin
      o_line = 1'b1; // Idle high like a pulled-up line
      nb = 10;
      cnt = 0;
      got = 13'h0;
   end
   // Receiver: confirm start at mid bit, then sample each bit centre
   always begin
      @(negedge i_line);
      repeat (i_bit_clks / 2) @(posedge i_clk);
      if (i_line === 1'b0) begin
         got = 13'h0;
         for (i = 0; i < nb; i = i + 1) begin
            repeat (i_bit_clks) @(posedge i_clk);
            got[i] = i_line;
         end
         cnt = cnt + 1;
      end
   end
   // Sender: bits go out first bit first, each held one bit time
   task send(input [12:0] bits, input integer n);
      integer k;
      begin
         for (k = 0; k < n; k = k + 1) begin
            @(negedge i_clk) o_line = bits[k];
            repeat (i_bit_clks - 1) @(negedge i_clk);
         end
      end
   endtask
endmodule // uart_peer

// ===== bench/tb.sv
// Self-checking bench for the serial datapath with a remote peer.
// Assumes inputs moved on falling edges; mostly asynchronous at divider zero.
`timescale 1ns/1ns
`define CHK(a, b) begin check_count = check_count + 1; if ((a) !== (b)) begin \
   fail_count = fail_count + 1; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAIT(c) begin k = 0; while (!(c) && k < 4000) begin @(negedge clk); k = k + 1; end \
   if (k >= 4000) begin fail_count = fail_count + 1; end_sim; end end
module tb;
   reg clk = 0, rstn = 0, en_tx = 1, en_rx = 0, dbl = 0, par = 0, odd = 0, stop2 = 0;
   reg ninth = 0, wr = 0, rd = 0, ie_e = 1, ie_c = 1, ack = 0, clr = 0;
   reg [2:0] size = 3'h3;
   reg sync = 0, xck = 0; // Synchronous mode and the clock pin that drives it
   reg [11:0] div = 12'h000; // Baud divider setting
   reg [7:0] wdata = 8'h00;
   reg [4:0] bclk = 5'h10; // Bit time in clocks, divider zero
   reg [8:0] v;
   wire [8:0] rdata;
   wire e_flag, c_flag, r_flag, e_irq, c_irq, sout, oe, owned, sin;
   integer fail_count = 0, check_count = 0, k, n, c0;
   always #5 clk = ~clk;
   uart_tx_rx_datapath uart_tx_rx_datapath_inst (.I_CLK(clk), .I_RSTN(rstn),
      .I_TX_ENABLE_BIT(en_tx), .I_RX_ENABLE_BIT(en_rx), .I_SYNC_MODE(sync),
      .I_DOUBLE_SPEED_BIT(dbl), .I_CHAR_SIZE_FIELD(size), .I_PARITY_ENABLE_BIT(par),
      .I_PARITY_ODD_SELECT(odd), .I_STOP_BITS_SELECT(stop2), .I_CLOCK_POLARITY_BIT(1'b0),
      .I_BAUD_DIVIDER(div), .I_TX_NINTH_BIT(ninth), .I_DATA_WR(wr), .I_DATA_WDATA(wdata),
      .I_DATA_RD(rd), .O_DATA_RDATA(rdata), .I_BUFFER_EMPTY_IRQ_ENABLE(ie_e),
      .I_TX_COMPLETE_IRQ_ENABLE(ie_c), .I_TX_COMPLETE_IRQ_ACK(ack),
      .I_TX_COMPLETE_CLEAR(clr), .O_BUFFER_EMPTY_FLAG(e_flag), .O_TX_COMPLETE_FLAG(c_flag),
      .O_RX_COMPLETE_FLAG(r_flag), .O_BUFFER_EMPTY_IRQ(e_irq), .O_TX_COMPLETE_IRQ(c_irq),
      .I_SERIAL_IN_PIN(sin), .I_SERIAL_CLOCK_PIN(xck), .O_SERIAL_OUT_PIN(sout),
      .O_SERIAL_OUT_OE(oe), .O_SERIAL_IN_OWNED(owned));
   uart_peer uart_peer_inst (.i_clk(clk), .i_bit_clks(bclk), .i_line(sout), .o_line(sin));
   // Verdict and stop, also reached from a timed-out wait
   task end_sim;
      begin
         if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // One data location write, taken at the rising edge in between
   task wr_byte(input [7:0] d);
      begin
         @(negedge clk) wr = 1'b1;
         wdata = d;
         @(negedge clk) wr = 1'b0;
      end
   endtask
   // Sample the head, then pop it
   task rd_byte(output [8:0] d);
      begin
         @(negedge clk) d = rdata;
         rd = 1'b1;
         @(negedge clk) rd = 1'b0;
      end
   endtask
   // Clear the completion flag by the write-one path
   task clr_tc;
      begin
         @(negedge clk) clr = 1'b1;
         @(negedge clk) clr = 1'b0;
         `CHK(c_flag, 1'b0)
      end
   endtask
   // Send one character and compare what the peer decoded
   task tx_case(input [2:0] sz, input p, input o, input s2, input d2, input n9, input [7:0] d);
      integer nd;
      reg [12:0] e;
      begin
         nd = (sz == 3'h7) ? 9 : sz + 5;
         e = {4'h0, n9, d} & ((13'h0001 << nd) - 13'h0001);
         if (p) e[nd] = ^e ^ o;
         e[nd + p] = 1'b1;
         size = sz; par = p; odd = o; stop2 = s2; dbl = d2; ninth = n9;
         // Peer bit time follows divider+1 at double speed, divider zero at normal speed; dividers 0 to 2 fit the peer's count
         bclk = d2 ? 5'h08 * (div[1:0] + 2'h1) : 5'h10;
         uart_peer_inst.nb = nd + p + 1;
         clr_tc;
         wr_byte(d);
         `WAIT(c_flag === 1'b1)
         `CHK(uart_peer_inst.got, e)
         `CHK(c_irq, 1'b1)
      end
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      tx_case(3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'ha5);
      tx_case(3'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'hff);
      tx_case(3'h2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h80);
      tx_case(3'h7, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h3c);
      div = 12'h001;
      tx_case(3'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h2b);
      div = 12'h000;
      // Back-to-back: second write waits in the buffer
      tx_case(3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
      clr_tc;
      c0 = uart_peer_inst.cnt;
      wr_byte(8'h5a);
      `CHK(e_flag, 1'b0)
      repeat (3) @(negedge clk);
      `CHK(e_flag, 1'b1)
      wr_byte(8'hc3);
      `CHK(e_flag, 1'b0)
      `CHK(e_irq, 1'b0)
      `WAIT(uart_peer_inst.cnt == c0 + 1)
      `CHK(uart_peer_inst.got, 13'h015a)
      `CHK(c_flag, 1'b0)
      `WAIT(c_flag === 1'b1)
      `CHK(uart_peer_inst.got, 13'h01c3)
      `CHK(e_irq, 1'b1)
      ie_e = 1'b0;
      @(negedge clk);
      `CHK(e_irq, 1'b0)
      // Disable just after the write, before the frame starts: pin held until the frame is out
      clr_tc;
      wr_byte(8'h33);
      en_tx = 1'b0;
      repeat (20) @(negedge clk);
      `CHK(oe, 1'b1)
      `WAIT(c_flag === 1'b1)
      repeat (3) @(negedge clk);
      `CHK(oe, 1'b0)
      `CHK(uart_peer_inst.got, 13'h0133)
      @(negedge clk) ack = 1'b1;
      @(negedge clk) ack = 1'b0;
      `CHK(c_flag, 1'b0)
      // Synchronous: bits change on the rising clock pin edge, taken at the falling one
      en_tx = 1'b1;
      sync = 1'b1;
      clr_tc;
      wr_byte(8'h96);
      v = 9'h000;
      // Pin period of eight clocks leaves room for the synchroniser delay
      for (n = 0; n < 11; n = n + 1) begin
         @(negedge clk) xck = 1'b1;
         repeat (4) @(negedge clk);
         if (n > 0 && n < 10) v = {sout, v[8:1]};
         xck = 1'b0;
         repeat (3) @(negedge clk);
      end
      `CHK(v, 9'h196)
      `CHK(c_flag, 1'b1)
      sync = 1'b0;
      // Receive: nine frames; eight fill the buffer, the ninth waits in the offer
      size = 3'h3; par = 1'b0; stop2 = 1'b1; dbl = 1'b0; bclk = 5'h10; en_rx = 1'b1;
      repeat (3) @(negedge clk);
      `CHK(owned, 1'b1)
      for (n = 0; n < 9; n = n + 1) uart_peer_inst.send({4'h1, n[3:0], n[3:0], 1'b0}, 10);
      repeat (2) @(negedge clk);
      `CHK(r_flag, 1'b1)
      for (n = 0; n < 9; n = n + 1) begin
         rd_byte(v);
         `CHK(v, {1'b0, n[3:0], n[3:0]})
      end
      `CHK(r_flag, 1'b0)
      size = 3'h0;
      uart_peer_inst.send({7'h01, 5'h15, 1'b0}, 7);
      repeat (2) @(negedge clk);
      rd_byte(v);
      `CHK(v, 9'h015)
      uart_peer_inst.send({7'h01, 5'h0a, 1'b0}, 7);
      repeat (2) @(negedge clk);
      `CHK(r_flag, 1'b1)
      en_rx = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(r_flag, 1'b0)
      `CHK(owned, 1'b0)
      end_sim;
   end
endmodule // tb
bind uart_tx_rx_datapath uart_dp_asserts uart_dp_asserts_inst (.I_CLK(I_CLK),
   .I_RSTN(I_RSTN), .I_TX_ENABLE_BIT(I_TX_ENABLE_BIT), .I_RX_ENABLE_BIT(I_RX_ENABLE_BIT),
   .I_SYNC_MODE(I_SYNC_MODE), .I_CHAR_SIZE_FIELD(I_CHAR_SIZE_FIELD),
   .I_BAUD_DIVIDER(I_BAUD_DIVIDER), .I_DATA_WR(I_DATA_WR),
   .I_BUFFER_EMPTY_IRQ_ENABLE(I_BUFFER_EMPTY_IRQ_ENABLE),
   .I_TX_COMPLETE_IRQ_ENABLE(I_TX_COMPLETE_IRQ_ENABLE),
   .I_TX_COMPLETE_IRQ_ACK(I_TX_COMPLETE_IRQ_ACK), .I_TX_COMPLETE_CLEAR(I_TX_COMPLETE_CLEAR),
   .O_DATA_RDATA(O_DATA_RDATA), .O_BUFFER_EMPTY_FLAG(O_BUFFER_EMPTY_FLAG),
   .O_TX_COMPLETE_FLAG(O_TX_COMPLETE_FLAG), .O_RX_COMPLETE_FLAG(O_RX_COMPLETE_FLAG),
   .O_BUFFER_EMPTY_IRQ(O_BUFFER_EMPTY_IRQ), .O_TX_COMPLETE_IRQ(O_TX_COMPLETE_IRQ),
   .O_SERIAL_OUT_PIN(O_SERIAL_OUT_PIN), .O_SERIAL_OUT_OE(O_SERIAL_OUT_OE),
   .O_SERIAL_IN_OWNED(O_SERIAL_IN_OWNED));
